// *** logic/tbm_map.svh ***
// register map, field positions, reset values and timing figures of the
// temperature and battery monitor; definitions only, included by bare name
`ifndef TBM_MAP_SVH
`define TBM_MAP_SVH

// register addresses (7-bit register port)
`define ADDR_INT_STATUS1   7'h03
`define ADDR_INT_STATUS2   7'h04
`define ADDR_INT_ENABLE2   7'h06
`define ADDR_OP_CONTROL1   7'h07
`define ADDR_CONV_CONFIG   7'h0F
`define ADDR_CONV_VALUE    7'h11
`define ADDR_TEMP_CONTROL  7'h12
`define ADDR_TEMP_OFFSET   7'h13
`define ADDR_BATT_THRESH   7'h1A
`define ADDR_BATT_LEVEL    7'h1B

// field positions
`define BIT_BATT_IRQ       2
`define BIT_BATT_ENABLE    6
`define BIT_CONV_TRIGGER   7
`define BIT_SHIFT_ENABLE   5
`define BIT_TRIM_ENABLE    4

// reset values
`define RST_TEMP_CONTROL   8'h20
`define RST_TEMP_OFFSET    8'h00
`define RST_BATT_THRESH    5'h14
`define RST_CONV_CONFIG    7'h00

// converter configuration fields, below the trigger bit
`define FLD_INPUT_SEL      6:4
`define FLD_REF_SEL        3:2
`define FLD_GAIN           1:0

// temperature sensor input code
`define SEL_TEMP_SENSOR    3'h0

// timing figures in their own units, then the low reading count
`define CLK_MHZ            40
`define CONV_TIME_US       350
`define BATT_PERIOD_MS     1000
`define BATT_WINDOW_US     250
`define LF_HZ              32768
`define LOW_READINGS       3'h4

`endif

// *** logic/tbm_pkg.sv ***
// types shared by the monitor and its battery sampler
// assumes tbm_map.svh supplies the numeric constants
package tbm_pkg;
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_BUSY = 2'b10
  } conv_state_e;

  typedef enum logic [1:0] {
    BATT_WAIT    = 2'b01,
    BATT_MEASURE = 2'b10
  } batt_state_e;
endpackage

// *** logic/battery_link_if.sv ***
// carrier between the monitor register file and the battery sampler
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface battery_link_if;
  logic       enable;     // detector switched on by software
  logic       sleep;      // chip in sleep, timebase from rc oscillator
  logic [4:0] threshold;  // low level threshold
  logic [4:0] level;      // latest battery reading
  logic       low_event;  // pulse: fourth consecutive low reading

  modport ctrl    (output enable, sleep, threshold, input level, low_event);
  modport sampler (input enable, sleep, threshold, output level, low_event);
endinterface

// *** logic/battery_sampler.sv ***
// periodic battery measurement and consecutive low reading counter
// assumes lf_tick is a one-cycle enable at the rc oscillator rate
`timescale 1ns/1ps
`include "tbm_map.svh"
module battery_sampler
  import tbm_pkg::*;
#(
  parameter int PERIOD_CYCLES = `BATT_PERIOD_MS * 1000 * `CLK_MHZ,
  parameter int WINDOW_CYCLES = `BATT_WINDOW_US * `CLK_MHZ,
  parameter int LF_PERIOD     = `BATT_PERIOD_MS * `LF_HZ / 1000,
  parameter int LF_WINDOW     = `BATT_WINDOW_US * `LF_HZ / 1000000
)(
  input  wire logic       clk,            // system clock
  input  wire logic       rst_n,          // synchronous reset, active low
  battery_link_if.sampler link,           // control and results
  input  wire logic       lf_tick,        // rc oscillator tick enable
  input  wire logic [4:0] bat_code,       // 5-bit converter output
  output logic            det_power_reg,  // detector and converter powered
  output logic            rc_osc_reg      // low frequency oscillator on
);
  batt_state_e state_reg, state_next;
  logic [31:0] count_reg, count_next;
  logic [4:0]  level_reg, level_next;
  logic [2:0]  low_cnt_reg, low_cnt_next;
  logic        event_reg, event_next;
  logic        det_power_next, rc_osc_next;
  logic        step;
  logic [31:0] period_lim, window_lim;

  // sleep counts oscillator ticks since the crystal clock rate is lost there
  assign step       = link.sleep ? lf_tick : 1'b1;
  assign period_lim = link.sleep ? 32'(LF_PERIOD) : 32'(PERIOD_CYCLES);
  assign window_lim = link.sleep ? 32'(LF_WINDOW) : 32'(WINDOW_CYCLES);

  // measurement scheduling, sampling and low counter
  always_comb
  begin
    state_next     = state_reg;
    count_next     = count_reg;
    level_next     = level_reg;
    low_cnt_next   = low_cnt_reg;
    event_next     = 1'b0;
    rc_osc_next    = link.enable && link.sleep;
    det_power_next = 1'b0;
    if (!link.enable)
    begin
      state_next   = BATT_WAIT;
      count_next   = 32'h0;
      low_cnt_next = 3'h0;
    end
    else
    begin
      case (state_reg)
        BATT_WAIT:
        begin
          if (step)
          begin
            if (count_reg + 32'h1 >= period_lim)
            begin
              state_next = BATT_MEASURE;
              count_next = 32'h0;
            end
            else
              count_next = count_reg + 32'h1;
          end
        end
        BATT_MEASURE:
        begin
          if (step)
          begin
            if (count_reg + 32'h1 >= window_lim)
            begin
              state_next = BATT_WAIT;
              count_next = 32'h0;
              level_next = bat_code;
              if (bat_code < link.threshold)
              begin
                if (low_cnt_reg < `LOW_READINGS)
                  low_cnt_next = low_cnt_reg + 3'h1;
                // one event per run of four or more low readings
                event_next = (low_cnt_reg == `LOW_READINGS - 3'h1);
              end
              else
                low_cnt_next = 3'h0;
            end
            else
              count_next = count_reg + 32'h1;
          end
        end
        default:
          state_next = BATT_WAIT;
      endcase
    end
    // power drops with the sampling edge, so the window is exactly its length
    if (state_next == BATT_MEASURE)
      det_power_next = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg     <= BATT_WAIT;
      count_reg     <= 32'h0;
      level_reg     <= 5'h00;
      low_cnt_reg   <= 3'h0;
      event_reg     <= 1'b0;
      det_power_reg <= 1'b0;
      rc_osc_reg    <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      count_reg     <= count_next;
      level_reg     <= level_next;
      low_cnt_reg   <= low_cnt_next;
      event_reg     <= event_next;
      det_power_reg <= det_power_next;
      rc_osc_reg    <= rc_osc_next;
    end
  end

  assign link.level     = level_reg;
  assign link.low_event = event_reg;
endmodule // battery_sampler

// *** logic/temp_and_battery_monitor.sv ***
// register file and digital side of the temperature sensor readout and
// the low battery detector; the analogue converters sit outside
// assumes the register port is driven by the serial slave in this clock
// domain and that converter codes are stable when sampled
`timescale 1ns/1ps
`include "tbm_map.svh"
module temp_and_battery_monitor
  import tbm_pkg::*;
#(
  parameter int CONV_CYCLES   = `CONV_TIME_US * `CLK_MHZ,
  parameter int PERIOD_CYCLES = `BATT_PERIOD_MS * 1000 * `CLK_MHZ,
  parameter int WINDOW_CYCLES = `BATT_WINDOW_US * `CLK_MHZ
)(
  input  wire logic       clk,                       // system clock, 40 MHz
  input  wire logic       rst_n,                     // synchronous reset
  input  wire logic [6:0] reg_addr,                  // register address
  input  wire logic [7:0] reg_wdata,                 // write data
  input  wire logic       reg_wr,                    // write strobe
  input  wire logic       reg_rd,                    // read strobe
  output logic      [7:0] reg_rdata,                 // read data, next cycle
  input  wire logic       sleep_mode,                // chip is in sleep
  input  wire logic       analog_test_temp_sel,      // temp voltage on test bus
  input  wire logic [7:0] conv_code,                 // 8-bit converter code
  input  wire logic [4:0] bat_code,                  // 5-bit converter code
  input  wire logic       lf_tick,                   // rc oscillator tick
  output logic            interrupt_request_n,       // interrupt, active low
  output logic            temp_sensor_power,         // sensor bias enable
  output logic            conv_start,                // converter start pulse
  output logic      [2:0] adc_input_select,          // converter input mux
  output logic      [1:0] adc_reference_select,      // converter reference
  output logic      [1:0] adc_gain,                  // amplifier gain
  output logic      [1:0] temp_range_select,         // sensor range
  output logic            temp_shift_enable,         // sensor range shift
  output logic            temp_analog_trim_enable,   // analogue trim on
  output logic      [3:0] temp_analog_trim_value,    // analogue trim code
  output logic            battery_detector_power,    // detector powered
  output logic            rc_osc_enable              // rc oscillator on
);
  battery_link_if link ();

  conv_state_e conv_state_reg, conv_state_next;
  logic [31:0] conv_cnt_reg, conv_cnt_next;
  logic [6:0]  conv_cfg_reg, conv_cfg_next;
  logic [7:0]  conv_value_reg, conv_value_next;
  logic [7:0]  temp_ctrl_reg, temp_ctrl_next;
  logic [7:0]  temp_offset_reg, temp_offset_next;
  logic [4:0]  thresh_reg, thresh_next;
  logic        batt_en_reg, batt_en_next;
  logic        batt_ie_reg, batt_ie_next;
  logic        batt_flag_reg, batt_flag_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        irq_n_reg, irq_n_next;
  logic        sensor_pwr_reg, sensor_pwr_next;
  logic        start_reg, start_next;

  // register select shared by the write and read paths
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  // offset add saturates so a large calibration cannot wrap to a cold reading
  function automatic logic [7:0] add_offset(input logic [7:0] code,
                                            input logic [7:0] offs);
    logic [8:0] sum;
    sum = {1'b0, code} + {1'b0, offs};
    add_offset = sum[8] ? 8'hFF : sum[7:0];
  endfunction

  // battery sampler shares the clock and gets its controls from here
  assign link.enable    = batt_en_reg;
  assign link.sleep     = sleep_mode;
  assign link.threshold = thresh_reg;

  battery_sampler #(
    .PERIOD_CYCLES (PERIOD_CYCLES),
    .WINDOW_CYCLES (WINDOW_CYCLES)
  ) u_sampler (
    .clk           (clk),
    .rst_n         (rst_n),
    .link          (link),
    .lf_tick       (lf_tick),
    .bat_code      (bat_code),
    .det_power_reg (battery_detector_power),
    .rc_osc_reg    (rc_osc_enable)
  );

  // control registers written by the host
  always_comb
  begin
    conv_cfg_next    = conv_cfg_reg;
    temp_ctrl_next   = temp_ctrl_reg;
    temp_offset_next = temp_offset_reg;
    thresh_next      = thresh_reg;
    batt_en_next     = batt_en_reg;
    batt_ie_next     = batt_ie_reg;
    if (reg_wr)
    begin
      if (hit(reg_addr, `ADDR_CONV_CONFIG))
        conv_cfg_next = reg_wdata[6:0];
      else if (hit(reg_addr, `ADDR_TEMP_CONTROL))
        temp_ctrl_next = reg_wdata;
      else if (hit(reg_addr, `ADDR_TEMP_OFFSET))
        temp_offset_next = reg_wdata;
      else if (hit(reg_addr, `ADDR_BATT_THRESH))
        thresh_next = reg_wdata[4:0];
      else if (hit(reg_addr, `ADDR_OP_CONTROL1))
        batt_en_next = reg_wdata[`BIT_BATT_ENABLE];
      else if (hit(reg_addr, `ADDR_INT_ENABLE2))
        batt_ie_next = reg_wdata[`BIT_BATT_IRQ];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      conv_cfg_reg    <= `RST_CONV_CONFIG;
      temp_ctrl_reg   <= `RST_TEMP_CONTROL;
      temp_offset_reg <= `RST_TEMP_OFFSET;
      thresh_reg      <= `RST_BATT_THRESH;
      batt_en_reg     <= 1'b0;
      batt_ie_reg     <= 1'b0;
    end
    else
    begin
      conv_cfg_reg    <= conv_cfg_next;
      temp_ctrl_reg   <= temp_ctrl_next;
      temp_offset_reg <= temp_offset_next;
      thresh_reg      <= thresh_next;
      batt_en_reg     <= batt_en_next;
      batt_ie_reg     <= batt_ie_next;
    end
  end

  // analogue controls come straight from the register flops
  assign adc_input_select        = conv_cfg_reg[`FLD_INPUT_SEL];
  assign adc_reference_select    = conv_cfg_reg[`FLD_REF_SEL];
  assign adc_gain                = conv_cfg_reg[`FLD_GAIN];
  assign temp_range_select       = temp_ctrl_reg[7:6];
  assign temp_shift_enable       = temp_ctrl_reg[`BIT_SHIFT_ENABLE];
  assign temp_analog_trim_enable = temp_ctrl_reg[`BIT_TRIM_ENABLE];
  assign temp_analog_trim_value  = temp_ctrl_reg[3:0];

  // conversion sequencer; a trigger while busy is ignored
  always_comb
  begin
    conv_state_next = conv_state_reg;
    conv_cnt_next   = conv_cnt_reg;
    conv_value_next = conv_value_reg;
    start_next      = 1'b0;
    case (conv_state_reg)
      CONV_IDLE:
      begin
        if (reg_wr && hit(reg_addr, `ADDR_CONV_CONFIG)
            && reg_wdata[`BIT_CONV_TRIGGER])
        begin
          conv_state_next = CONV_BUSY;
          conv_cnt_next   = 32'h0;
          start_next      = 1'b1;
        end
      end
      CONV_BUSY:
      begin
        if (conv_cnt_reg + 32'h1 >= 32'(CONV_CYCLES))
        begin
          conv_state_next = CONV_IDLE;
          // offset enable shares the shift bit, so the sum only applies
          // in the shifted ranges
          if (temp_ctrl_reg[`BIT_SHIFT_ENABLE])
            conv_value_next = add_offset(conv_code, temp_offset_reg);
          else
            conv_value_next = conv_code;
        end
        else
          conv_cnt_next = conv_cnt_reg + 32'h1;
      end
      default:
        conv_state_next = CONV_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      conv_state_reg <= CONV_IDLE;
      conv_cnt_reg   <= 32'h0;
      conv_value_reg <= 8'h00;
      start_reg      <= 1'b0;
    end
    else
    begin
      conv_state_reg <= conv_state_next;
      conv_cnt_reg   <= conv_cnt_next;
      conv_value_reg <= conv_value_next;
      start_reg      <= start_next;
    end
  end

  assign conv_start = start_reg;

  // interrupt flag, line and sensor power; set wins over the read clear
  always_comb
  begin
    batt_flag_next = batt_flag_reg;
    if (reg_rd && hit(reg_addr, `ADDR_INT_STATUS2))
      batt_flag_next = 1'b0;
    if (link.low_event)
      batt_flag_next = 1'b1;
    irq_n_next      = !(batt_flag_next && batt_ie_reg);
    sensor_pwr_next = (conv_cfg_reg[`FLD_INPUT_SEL] == `SEL_TEMP_SENSOR)
                      || analog_test_temp_sel;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      batt_flag_reg  <= 1'b0;
      irq_n_reg      <= 1'b1;
      sensor_pwr_reg <= 1'b0;
    end
    else
    begin
      batt_flag_reg  <= batt_flag_next;
      irq_n_reg      <= irq_n_next;
      sensor_pwr_reg <= sensor_pwr_next;
    end
  end

  assign interrupt_request_n = irq_n_reg;
  assign temp_sensor_power   = sensor_pwr_reg;

  // read mux, registered; unmapped addresses read zero
  always_comb
  begin
    rdata_next = rdata_reg;
    if (reg_rd)
    begin
      rdata_next = 8'h00;
      if (hit(reg_addr, `ADDR_CONV_CONFIG))
        rdata_next = {conv_state_reg == CONV_BUSY, conv_cfg_reg};
      else if (hit(reg_addr, `ADDR_CONV_VALUE))
        rdata_next = conv_value_reg;
      else if (hit(reg_addr, `ADDR_TEMP_CONTROL))
        rdata_next = temp_ctrl_reg;
      else if (hit(reg_addr, `ADDR_TEMP_OFFSET))
        rdata_next = temp_offset_reg;
      else if (hit(reg_addr, `ADDR_BATT_THRESH))
        rdata_next = {3'h0, thresh_reg};
      else if (hit(reg_addr, `ADDR_BATT_LEVEL))
        rdata_next = {3'h0, link.level};
      else if (hit(reg_addr, `ADDR_OP_CONTROL1))
        rdata_next[`BIT_BATT_ENABLE] = batt_en_reg;
      else if (hit(reg_addr, `ADDR_INT_ENABLE2))
        rdata_next[`BIT_BATT_IRQ] = batt_ie_reg;
      else if (hit(reg_addr, `ADDR_INT_STATUS2))
        rdata_next[`BIT_BATT_IRQ] = batt_flag_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  assign reg_rdata = rdata_reg;
endmodule // temp_and_battery_monitor

// *** bench/tbm_monitor.sv ***
// concurrent checks on the monitor's ports, bound into every instance
// assumes one clock, clk, and rst_n synchronous active low
`timescale 1ns/1ps
module tbm_monitor (
  input wire logic       clk,                    // system clock
  input wire logic       rst_n,                  // reset, active low
  input wire logic [6:0] reg_addr,               // register address
  input wire logic [7:0] reg_wdata,              // write data
  input wire logic       reg_wr,                 // write strobe
  input wire logic       reg_rd,                 // read strobe
  input wire logic [7:0] reg_rdata,              // read data
  input wire logic       sleep_mode,             // chip in sleep
  input wire logic       analog_test_temp_sel,   // sensor on test bus
  input wire logic       interrupt_request_n,    // interrupt, active low
  input wire logic       temp_sensor_power,      // sensor bias
  input wire logic       conv_start,             // converter start
  input wire logic [2:0] adc_input_select,       // converter input mux
  input wire logic       battery_detector_power, // detector powered
  input wire logic       rc_osc_enable           // rc oscillator on
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // a read strobe at one address
  sequence rd_s(logic [6:0] a);
    reg_rd && reg_addr == a;
  endsequence

  // one measurement window: ten cycles powered, then off
  sequence window_s;
    battery_detector_power [*8] ##1 battery_detector_power ##1 battery_detector_power
      ##1 !battery_detector_power;
  endsequence

  // bias may lag the select by a register stage, so allow two edges
  sensor_power_a: assert property (
    (adc_input_select == 3'h0 || analog_test_temp_sel) |-> ##[0:2] temp_sensor_power)
    else $error("sensor bias missing");
  conv_cause_a: assert property (
    conv_start |-> $past(reg_wr && reg_addr == 7'h0F && reg_wdata[7]))
    else $error("start without trigger write");
  conv_gap_a: assert property (
    conv_start |=> !conv_start [*8])
    else $error("trigger taken while busy");
  // sleep windows are timed by the rc tick, so they are exempt here
  window_len_a: assert property (disable iff (!rst_n || sleep_mode)
    $rose(battery_detector_power) |-> window_s)
    else $error("measurement window length wrong");
  idle_gap_a: assert property (
    $fell(battery_detector_power) |-> !battery_detector_power [*8])
    else $error("detector powered again too soon");
  level_read_a: assert property (
    rd_s(7'h1B) |=> reg_rdata[7:5] == 3'h0)
    else $error("level upper bits not zero");
  thresh_read_a: assert property (
    rd_s(7'h1A) |=> reg_rdata[7:5] == 3'h0)
    else $error("threshold upper bits not zero");
  irq_release_a: assert property (
    rd_s(7'h04) and !interrupt_request_n |-> ##[1:2] interrupt_request_n)
    else $error("interrupt not released by status read");
  irq_cause_a: assert property (
    $fell(interrupt_request_n) |-> $past(battery_detector_power, 2)
      || $past(battery_detector_power, 3) || $past(battery_detector_power, 4))
    else $error("interrupt not after a measurement");
  rc_osc_a: assert property (
    !$past(sleep_mode) |-> !rc_osc_enable)
    else $error("rc oscillator on outside sleep");
endmodule // tbm_monitor

bind temp_and_battery_monitor tbm_monitor i_mon (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_mode,
  .analog_test_temp_sel, .interrupt_request_n, .temp_sensor_power, .conv_start,
  .adc_input_select, .battery_detector_power, .rc_osc_enable
);

// *** bench/afe_model.sv ***
// behavioural analogue front end: 8-bit and 5-bit converters, rc tick
// assumes CONV_CYCLES matches the monitor instance
`timescale 1ns/1ps
module afe_model #(
  parameter int CONV_CYCLES = 20
)(
  input  wire logic       clk,        // system clock
  input  wire logic       conv_start, // converter start pulse
  input  wire logic       bat_power,  // detector powered
  input  wire logic [7:0] conv_val,   // temperature code to deliver
  input  wire logic [4:0] bat_val,    // battery code to deliver
  output logic      [7:0] conv_code,  // 8-bit converter output
  output logic      [4:0] bat_code,   // 5-bit converter output
  output logic            lf_tick     // rc oscillator tick
);
  int conv_cnt = 0;
  int tick_cnt = 0;
  initial
  begin
    conv_code = 8'h00;
    bat_code = 5'h00;
    lf_tick = 1'b0;
  end
  // codes are valid only while converting; outside they toggle each cycle,
  // so a design sampling at the wrong moment reads garbage
  always @(posedge clk)
  begin
    conv_cnt <= conv_start ? CONV_CYCLES + 2 : (conv_cnt > 0 ? conv_cnt - 1 : 0);
    conv_code <= (conv_start || conv_cnt > 1) ? conv_val : ~conv_code;
    bat_code <= bat_power ? bat_val : ~bat_code;
    tick_cnt <= (tick_cnt == 0) ? 7 : tick_cnt - 1;
    lf_tick <= (tick_cnt == 0);
  end
endmodule // afe_model

// *** bench/tb.sv ***
// self-checking bench: register tasks drive the monitor, the front end
// model supplies converter codes; long counts shortened by parameters
`timescale 1ns/1ps
module tb;
  localparam int CONV = 20;
  localparam int PER  = 200;
  localparam int WIN  = 10;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       sleep_mode = 1'b0;
  logic       analog_test_temp_sel = 1'b0;
  logic [7:0] conv_val = 8'h00;
  logic [4:0] bat_val = 5'h1F;
  logic [7:0] reg_rdata, conv_code, d;
  logic [4:0] bat_code;
  logic [3:0] temp_analog_trim_value;
  logic [2:0] adc_input_select;
  logic [1:0] adc_reference_select, adc_gain, temp_range_select;
  logic       lf_tick, interrupt_request_n, temp_sensor_power, conv_start;
  logic       temp_shift_enable, temp_analog_trim_enable;
  logic       battery_detector_power, rc_osc_enable;
  logic [8:0] sum;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cyc = 0;
  int         t0, n;
  int         t [4];
  logic [6:0] ra [8] = '{7'h12, 7'h13, 7'h1A, 7'h0F, 7'h06, 7'h07, 7'h03, 7'h7F};
  logic [7:0] rv [8] = '{8'h20, 8'h00, 8'h14, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] cc [5] = '{8'h20, 8'h60, 8'hA0, 8'hE0, 8'h80};
  logic [7:0] co [5] = '{8'h10, 8'h00, 8'h10, 8'h01, 8'h10};
  logic [7:0] cv [5] = '{8'h40, 8'h7F, 8'hF8, 8'hFF, 8'h33};

  temp_and_battery_monitor #(.CONV_CYCLES(CONV), .PERIOD_CYCLES(PER), .WINDOW_CYCLES(WIN))
  i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_mode,
    .analog_test_temp_sel, .conv_code, .bat_code, .lf_tick, .interrupt_request_n,
    .temp_sensor_power, .conv_start, .adc_input_select, .adc_reference_select, .adc_gain,
    .temp_range_select, .temp_shift_enable, .temp_analog_trim_enable,
    .temp_analog_trim_value, .battery_detector_power, .rc_osc_enable);
  afe_model #(.CONV_CYCLES(CONV)) i_afe (.clk, .conv_start, .bat_power(battery_detector_power),
    .conv_val, .bat_val, .conv_code, .bat_code, .lf_tick);

  // clock and a free cycle count for timing measurements
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle strobes launched just after an edge, released after the next
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk);
    #2;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #2;
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    cmp(v, e);
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  // waits through one measurement window, bounded, and notes its start
  task automatic win(output int tr);
    int k;
    k = 0;
    while (battery_detector_power !== 1'b1 && k < 400)
    begin
      cycles(1);
      k++;
    end
    tr = cyc;
    while (battery_detector_power !== 1'b0 && k < 440)
    begin
      cycles(1);
      k++;
    end
    cmp(8'(k < 440), 8'h01);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog well beyond the few thousand cycles the tests take
  initial
  begin
    #(25 * 20000);
    miscompares++;
    stop_test();
  end

  initial
  begin
    cycles(12);
    rst_n = 1'b1;
    wr(7'h7F, 8'hFF);
    for (int i = 0; i < 8; i++)
      rdc(ra[i], rv[i]);
    cmp(8'(temp_sensor_power), 8'h01);
    $display("test reset values done");
    wr(7'h1A, 8'hFF);
    rdc(7'h1A, 8'h1F);
    wr(7'h12, 8'h9A);
    cmp({temp_range_select, temp_shift_enable, temp_analog_trim_enable,
      temp_analog_trim_value}, 8'h9A);
    wr(7'h0F, 8'h1B);
    cmp({1'b0, adc_input_select, adc_reference_select, adc_gain}, 8'h1B);
    cycles(3);
    cmp(8'(temp_sensor_power), 8'h00);
    analog_test_temp_sel = 1'b1;
    cycles(3);
    cmp(8'(temp_sensor_power), 8'h01);
    analog_test_temp_sel = 1'b0;
    $display("test fields and sensor power done");
    for (int i = 0; i < 5; i++)
    begin
      wr(7'h12, cc[i]);
      wr(7'h13, co[i]);
      conv_val = cv[i];
      wr(7'h0F, 8'h80);
      t0 = cyc;
      rdc(7'h0F, 8'h80);
      wr(7'h0F, 8'h80);
      d = 8'h80;
      for (int k = 0; k < 30 && d[7] === 1'b1; k++)
        rd(7'h0F, d);
      cmp(8'(cyc - t0 >= CONV && cyc - t0 <= CONV + 4), 8'h01);
      sum = {1'b0, cv[i]} + {1'b0, co[i]};
      cmp(8'(temp_range_select), 8'(cc[i][7:6]));
      rdc(7'h11, cc[i][5] ? (sum[8] ? 8'hFF : sum[7:0]) : cv[i]);
      // host scaling in range 01: one degree per step from -64
      if (i == 1)
      begin
        rd(7'h11, d);
        cmp(d - 8'h40, 8'h3F);
      end
    end
    $display("test conversions done");
    wr(7'h1A, 8'h14);
    wr(7'h06, 8'h04);
    bat_val = 5'h0A;
    wr(7'h07, 8'h40);
    rdc(7'h07, 8'h40);
    for (int i = 0; i < 4; i++)
    begin
      win(t[i]);
      cycles(4);
      cmp(8'(interrupt_request_n), (i < 3) ? 8'h01 : 8'h00);
    end
    cmp(8'(t[1] - t[0] >= PER + WIN - 2 && t[1] - t[0] <= PER + WIN + 2), 8'h01);
    rdc(7'h1B, 8'h0A);
    rdc(7'h03, 8'h00);
    rd(7'h04, d);
    cmp(d & 8'h04, 8'h04);
    cycles(2);
    cmp(8'(interrupt_request_n), 8'h01);
    rd(7'h04, d);
    cmp(d & 8'h04, 8'h00);
    wr(7'h06, 8'h00);
    bat_val = 5'h14;
    win(t[0]);
    bat_val = 5'h0A;
    for (int i = 0; i < 3; i++)
      win(t[i]);
    rd(7'h04, d);
    cmp(d & 8'h04, 8'h00);
    win(t[3]);
    cycles(4);
    cmp(8'(interrupt_request_n), 8'h01);
    rd(7'h04, d);
    cmp(d & 8'h04, 8'h04);
    $display("test battery detector done");
    wr(7'h07, 8'h00);
    n = 0;
    repeat (300)
    begin
      cycles(1);
      if (battery_detector_power !== 1'b0)
        n++;
    end
    cmp(8'(n == 0), 8'h01);
    wr(7'h07, 8'h40);
    sleep_mode = 1'b1;
    cycles(3);
    cmp(8'(rc_osc_enable), 8'h01);
    sleep_mode = 1'b0;
    cycles(3);
    cmp(8'(rc_osc_enable), 8'h00);
    $display("test disable and sleep done");
    stop_test();
  end
endmodule // tb
